// ### hdl/tcc_top.sv
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// Behaviour
// - action field: 00 none, 01 toggle, 10 clear, 11 set the pin
// - a nonzero action field makes the pin an output of the channel
// - action field acts on the port only while its ch7 mask bit is zero
// - output disconnect bit set keeps the pin undriven
// - without precision mode the counter tick is bus clock over 1..128
// - precision mode divides by the eight-bit register plus one, 1..256
// - input capture copies the counter on an active pin edge
// - capture or compare sets the flag; request only when enabled
// - flags clear by writing one while timer or accumulator enabled
// - output compare acts on the pin when counter equals channel register
// - force compare performs the action without setting the flag
// - a channel-7 event overrides compare actions of other channels
// - channel-7 event copies data bits where the mask bit is set
// - counter reset enable makes a channel-7 match clear the counter
// - bits of absent channels ignore writes and read zero
// - main counter is a 16-bit up counter on each tick
// - the masked channel-7 data goes into the port data register
module tcc_top
   import tcc_pkg::*;
#(
   parameter logic [7:0] CH_EN = 8'hFF
)(
   // apb slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // timer pins
   input  wire logic [7:0]  tc_in,
   output logic      [7:0]  tc_out,
   output logic      [7:0]  tc_oe,
   // channel requests
   output logic      [7:0]  chan_irq
);
   // registers
   logic [7:0]  ctrl1_ff, ctrl2_ff, dir_ff, mask7_ff, data7_ff;
   logic [7:0]  ien_ff, flags_ff, overflow_toggle_bits_ff, disc_ff, pps_ff, port_ff;
   logic [15:0] action_ff, edge_ff, cnt_ff;
   logic [15:0] tc_ff [NCH];
   logic [31:0] prdata_ff;
   logic [7:0]  in_s1_ff, in_s2_ff, in_s3_ff;
   logic [7:0]  nxt_ctrl1, nxt_ctrl2, nxt_dir, nxt_mask7, nxt_data7;
   logic [7:0]  nxt_ien, nxt_flags, nxt_overflow_toggle_bits, nxt_disc, nxt_pps, nxt_port;
   logic [15:0] nxt_action, nxt_edge, nxt_cnt;
   logic [15:0] nxt_tc [NCH];
   logic [31:0] nxt_prdata;
   // working signals
   logic        wr, rd_setup, mapped, cnt_inc, ovf, ch7_evt, cnt_clr;
   logic [15:0] cnt_plus;
   logic [7:0]  match, force_wr, fire, capture, clr, act_on;
   logic [2:0]  cidx;
   logic        chan_sel;

   tcc_presc_if pif ();

   tcc_prescaler u_presc (
      .pclk    (pclk),
      .presetn (presetn),
      .pif     (pif)
   );

   assign pif.enable  = ctrl1_ff[CTRL1_TEN];
   assign pif.precise = ctrl1_ff[CTRL1_PRECISION_PRESCALER_MODE];
   assign pif.sel     = ctrl2_ff[2:0];
   assign pif.ratio   = pps_ff;

   function automatic logic wr_hit(input logic w, input logic [7:0] a,
                                   input logic [7:0] ofs);
      wr_hit = w && (a == ofs);
   endfunction : wr_hit

   // spread a channel mask over two-bit fields
   function automatic logic [15:0] pair_mask(input logic [7:0] m);
      for (int i = 0; i < NCH; i++) begin
         pair_mask[2*i +: 2] = {m[i], m[i]};
      end
   endfunction : pair_mask

   function automatic logic apply_act(input logic [1:0] act,
                                      input logic cur);
      case (act)
         ACT_TOGGLE: apply_act = ~cur;
         ACT_CLEAR:  apply_act = 1'b0;
         ACT_SET:    apply_act = 1'b1;
         default:    apply_act = cur;
      endcase
   endfunction : apply_act

   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic prev, input logic cur);
      case (sel)
         EDGE_RISE: edge_hit = !prev && cur;
         EDGE_FALL: edge_hit = prev && !cur;
         EDGE_ANY:  edge_hit = prev != cur;
         default:   edge_hit = 1'b0;
      endcase
   endfunction : edge_hit

   // timer event logic
   always_comb begin
      cnt_inc  = ctrl1_ff[CTRL1_TEN] && pif.tick;
      cnt_plus = cnt_ff + CNT_STEP;
      ovf      = cnt_inc && (cnt_ff == CNT_MAX);
      for (int i = 0; i < NCH; i++) begin
         match[i]   = CH_EN[i] && cnt_inc && dir_ff[i]
                      && (cnt_plus == tc_ff[i]);
         act_on[i]  = action_ff[2*i +: 2] != ACT_NONE;
         capture[i] = CH_EN[i] && !dir_ff[i]
                      && edge_hit(edge_ff[2*i +: 2], in_s3_ff[i],
                                  in_s2_ff[i]);
      end
      cnt_clr  = CH_EN[CH7] && ctrl2_ff[CTRL2_COUNTER_RESET_ENABLE] && cnt_inc
                 && (cnt_plus == tc_ff[CH7]);
      ch7_evt  = CH_EN[CH7] && (match[CH7]
                 || (ovf && overflow_toggle_bits_ff[CH7]));
      wr       = psel && penable && pwrite;
      force_wr = wr_hit(wr, paddr, OFS_FORCE) ?
                 (pwdata[7:0] & CH_EN & dir_ff) : RST_BYTE;
      for (int i = 0; i < NCH; i++) begin
         fire[i] = (match[i] || force_wr[i]) && !mask7_ff[i]
                   && (!ch7_evt || i == CH7);
      end
   end

   // apb decode and register next values
   always_comb begin
      rd_setup   = psel && !penable && !pwrite;
      chan_sel   = (paddr[7:6] == CHAN_PAGE) && !paddr[5];
      cidx       = paddr[4:2];
      mapped     = chan_sel || (paddr <= OFS_EDGE && paddr[1:0] == 2'b00);
      nxt_ctrl1  = ctrl1_ff;
      nxt_ctrl2  = ctrl2_ff;
      nxt_dir    = dir_ff;
      nxt_mask7  = mask7_ff;
      nxt_data7  = data7_ff;
      nxt_ien    = ien_ff;
      nxt_overflow_toggle_bits   = overflow_toggle_bits_ff;
      nxt_disc   = disc_ff;
      nxt_pps    = pps_ff;
      nxt_action = action_ff;
      nxt_edge   = edge_ff;
      nxt_tc     = tc_ff;
      nxt_prdata = prdata_ff;
      if (wr_hit(wr, paddr, OFS_CTRL1)) nxt_ctrl1 = pwdata[7:0] & 8'h89;
      if (wr_hit(wr, paddr, OFS_CTRL2)) nxt_ctrl2 = pwdata[7:0] & 8'h0F;
      if (wr_hit(wr, paddr, OFS_DIR))   nxt_dir   = pwdata[7:0] & CH_EN;
      if (wr_hit(wr, paddr, OFS_MASK7)) nxt_mask7 = pwdata[7:0] & CH_EN;
      if (wr_hit(wr, paddr, OFS_DATA7)) nxt_data7 = pwdata[7:0] & CH_EN;
      if (wr_hit(wr, paddr, OFS_IEN))   nxt_ien   = pwdata[7:0] & CH_EN;
      if (wr_hit(wr, paddr, OFS_TOGGLE)) nxt_overflow_toggle_bits = pwdata[7:0] & CH_EN;
      if (wr_hit(wr, paddr, OFS_DISC))  nxt_disc  = pwdata[7:0] & CH_EN;
      if (wr_hit(wr, paddr, OFS_PPS))   nxt_pps   = pwdata[7:0];
      if (wr_hit(wr, paddr, OFS_ACTION)) begin
         nxt_action = pwdata[15:0] & pair_mask(CH_EN);
      end
      if (wr_hit(wr, paddr, OFS_EDGE)) begin
         nxt_edge = pwdata[15:0] & pair_mask(CH_EN);
      end
      for (int i = 0; i < NCH; i++) begin
         if (wr && chan_sel && cidx == 3'(i) && CH_EN[i]) begin
            nxt_tc[i] = pwdata[15:0];
         end
         if (capture[i]) begin
            nxt_tc[i] = cnt_ff;
         end
      end
      // flags: set wins over a write-one clear
      clr = (wr_hit(wr, paddr, OFS_FLAGS)
             && (ctrl1_ff[CTRL1_TEN] || ctrl1_ff[CTRL1_PULSE_ACCUM_ENABLE])) ?
            pwdata[7:0] : RST_BYTE;
      nxt_flags = ((flags_ff & ~clr) | capture | match) & CH_EN;
      // counter
      nxt_cnt = cnt_ff;
      if (cnt_inc) begin
         nxt_cnt = cnt_clr ? RST_WORD : cnt_plus;
      end
      // port data register
      nxt_port = port_ff;
      for (int i = 0; i < NCH; i++) begin
         if (fire[i]) begin
            nxt_port[i] = apply_act(action_ff[2*i +: 2], port_ff[i]);
         end
      end
      if (ch7_evt) begin
         nxt_port = (nxt_port & ~mask7_ff)
                    | (data7_ff & mask7_ff);
      end
      // read data captured in the setup cycle
      if (rd_setup) begin
         nxt_prdata = 32'h0000_0000;
         if (chan_sel) begin
            nxt_prdata[15:0] = CH_EN[cidx] ? tc_ff[cidx] : RST_WORD;
         end else begin
            case (paddr)
               OFS_CTRL1:  nxt_prdata[7:0]  = ctrl1_ff;
               OFS_CTRL2:  nxt_prdata[7:0]  = ctrl2_ff;
               OFS_DIR:    nxt_prdata[7:0]  = dir_ff;
               OFS_MASK7:  nxt_prdata[7:0]  = mask7_ff;
               OFS_DATA7:  nxt_prdata[7:0]  = data7_ff;
               OFS_COUNT:  nxt_prdata[15:0] = cnt_ff;
               OFS_ACTION: nxt_prdata[15:0] = action_ff;
               OFS_IEN:    nxt_prdata[7:0]  = ien_ff;
               OFS_FLAGS:  nxt_prdata[7:0]  = flags_ff;
               OFS_TOGGLE: nxt_prdata[7:0]  = overflow_toggle_bits_ff;
               OFS_DISC:   nxt_prdata[7:0]  = disc_ff;
               OFS_PPS:    nxt_prdata[7:0]  = pps_ff;
               OFS_PORT:   nxt_prdata[7:0]  = port_ff;
               OFS_EDGE:   nxt_prdata[15:0] = edge_ff;
               default:    nxt_prdata       = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl1_ff  <= RST_BYTE;
         ctrl2_ff  <= RST_BYTE;
         dir_ff    <= RST_BYTE;
         mask7_ff  <= RST_BYTE;
         data7_ff  <= RST_BYTE;
         ien_ff    <= RST_BYTE;
         flags_ff  <= RST_BYTE;
         overflow_toggle_bits_ff   <= RST_BYTE;
         disc_ff   <= RST_BYTE;
         pps_ff    <= RST_BYTE;
         port_ff   <= RST_BYTE;
         action_ff <= RST_WORD;
         edge_ff   <= RST_WORD;
         cnt_ff    <= RST_WORD;
         prdata_ff <= 32'h0000_0000;
         in_s1_ff  <= RST_BYTE;
         in_s2_ff  <= RST_BYTE;
         in_s3_ff  <= RST_BYTE;
         for (int i = 0; i < NCH; i++) begin
            tc_ff[i] <= RST_WORD;
         end
      end else begin
         ctrl1_ff  <= nxt_ctrl1;
         ctrl2_ff  <= nxt_ctrl2;
         dir_ff    <= nxt_dir;
         mask7_ff  <= nxt_mask7;
         data7_ff  <= nxt_data7;
         ien_ff    <= nxt_ien;
         flags_ff  <= nxt_flags;
         overflow_toggle_bits_ff   <= nxt_overflow_toggle_bits;
         disc_ff   <= nxt_disc;
         pps_ff    <= nxt_pps;
         port_ff   <= nxt_port;
         action_ff <= nxt_action;
         edge_ff   <= nxt_edge;
         cnt_ff    <= nxt_cnt;
         prdata_ff <= nxt_prdata;
         in_s1_ff  <= tc_in;
         in_s2_ff  <= in_s1_ff;
         in_s3_ff  <= in_s2_ff;
         tc_ff     <= nxt_tc;
      end
   end

   // outputs
   always_comb begin
      prdata   = prdata_ff;
      pready   = psel && penable;
      pslverr  = psel && penable && !mapped;
      tc_out   = port_ff;
      tc_oe    = (act_on | (dir_ff & mask7_ff)) & ~disc_ff & CH_EN;
      chan_irq = flags_ff & ien_ff;
   end

   // checks
   sequence s_fire1(logic [1:0] a);
      fire[1] && action_ff[3:2] == a;
   endsequence

   property p_set;
      @(posedge pclk) disable iff (!presetn)
      s_fire1(ACT_SET) ##0 !ch7_evt |=> tc_out[1];
   endproperty
   a_set: assert property (p_set)
      else $error("set action did not drive one");

   property p_toggle;
      @(posedge pclk) disable iff (!presetn)
      s_fire1(ACT_TOGGLE) ##0 !ch7_evt |=> tc_out[1] != $past(tc_out[1]);
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("toggle action did not invert pin");

   property p_oe;
      @(posedge pclk) disable iff (!presetn)
      disc_ff[1] |-> !tc_oe[1];
   endproperty
   a_oe: assert property (p_oe)
      else $error("disconnected pin still driven");

   property p_mask_block;
      @(posedge pclk) disable iff (!presetn)
      match[1] && mask7_ff[1] && !ch7_evt && $stable(tc_out[1])
      |=> tc_out[1] == $past(tc_out[1]);
   endproperty
   a_mask_block: assert property (p_mask_block)
      else $error("masked channel changed the port");

   property p_capture;
      @(posedge pclk) disable iff (!presetn)
      capture[0] |=> flags_ff[0];
   endproperty
   a_capture: assert property (p_capture)
      else $error("capture flag missing");

   property p_capval;
      @(posedge pclk) disable iff (!presetn)
      capture[0] |=> tc_ff[0] == $past(cnt_ff);
   endproperty
   a_capval: assert property (p_capval)
      else $error("capture value wrong");

   property p_force;
      @(posedge pclk) disable iff (!presetn)
      force_wr[1] && !match[1] && !capture[1] && !clr[1]
      |=> flags_ff[1] == $past(flags_ff[1]);
   endproperty
   a_force: assert property (p_force)
      else $error("forced compare touched the flag");

   property p_counter_reset_enable;
      @(posedge pclk) disable iff (!presetn)
      cnt_clr |=> cnt_ff == RST_WORD;
   endproperty
   a_counter_reset_enable: assert property (p_counter_reset_enable)
      else $error("channel 7 match did not reset counter");

   property p_count;
      @(posedge pclk) disable iff (!presetn)
      cnt_inc && !cnt_clr |=> cnt_ff == $past(cnt_ff) + CNT_STEP;
   endproperty
   a_count: assert property (p_count)
      else $error("counter did not advance by one");

   property p_data7;
      @(posedge pclk) disable iff (!presetn)
      ch7_evt && mask7_ff[1] |=> tc_out[1] == $past(data7_ff[1]);
   endproperty
   a_data7: assert property (p_data7)
      else $error("channel 7 data not copied");
endmodule : tcc_top

// ### hdl/tcc_pkg.sv
package tcc_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL1  = 8'h00;
   localparam logic [7:0] OFS_CTRL2  = 8'h04;
   localparam logic [7:0] OFS_DIR    = 8'h08;
   localparam logic [7:0] OFS_FORCE  = 8'h0C;
   localparam logic [7:0] OFS_MASK7  = 8'h10;
   localparam logic [7:0] OFS_DATA7  = 8'h14;
   localparam logic [7:0] OFS_COUNT  = 8'h18;
   localparam logic [7:0] OFS_ACTION = 8'h1C;
   localparam logic [7:0] OFS_IEN    = 8'h20;
   localparam logic [7:0] OFS_FLAGS  = 8'h24;
   localparam logic [7:0] OFS_TOGGLE = 8'h28;
   localparam logic [7:0] OFS_DISC   = 8'h2C;
   localparam logic [7:0] OFS_PPS    = 8'h30;
   localparam logic [7:0] OFS_PORT   = 8'h34;
   localparam logic [7:0] OFS_EDGE   = 8'h38;
   localparam logic [7:0] OFS_CHAN   = 8'h40;
   localparam logic [1:0] CHAN_PAGE  = 2'h1;
   // field positions
   localparam int CTRL1_TEN  = 7;
   localparam int CTRL1_PRECISION_PRESCALER_MODE = 3;
   localparam int CTRL1_PULSE_ACCUM_ENABLE = 0;
   localparam int CTRL2_COUNTER_RESET_ENABLE = 3;
   // reset values and other constants
   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic [15:0] RST_WORD  = 16'h0000;
   localparam logic [15:0] CNT_MAX   = 16'hFFFF;
   localparam logic [15:0] CNT_STEP  = 16'h0001;
   localparam logic [7:0]  DIV_STEP  = 8'h01;
   localparam int          NCH       = 8;
   localparam int          CH7       = 7;

   typedef enum logic [1:0] {
      ACT_NONE   = 2'b00,
      ACT_TOGGLE = 2'b01,
      ACT_CLEAR  = 2'b10,
      ACT_SET    = 2'b11
   } tcc_act_t;

   typedef enum logic [1:0] {
      EDGE_OFF  = 2'b00,
      EDGE_RISE = 2'b01,
      EDGE_FALL = 2'b10,
      EDGE_ANY  = 2'b11
   } tcc_edge_t;
endpackage : tcc_pkg

// ### hdl/tcc_presc_if.sv
`timescale 1ns/1ps
interface tcc_presc_if;
   logic       enable;
   logic       precise;
   logic [2:0] sel;
   logic [7:0] ratio;
   logic       tick;
   modport cfg  (output enable, precise, sel, ratio, input tick);
   modport core (input enable, precise, sel, ratio, output tick);
endinterface : tcc_presc_if

// ### hdl/tcc_prescaler.sv
`timescale 1ns/1ps
module tcc_prescaler
   import tcc_pkg::*;
(
   // clock and reset
   input wire logic   pclk,
   input wire logic   presetn,
   // configuration and tick
   tcc_presc_if.core  pif
);
   logic [7:0] div_ff;
   logic [7:0] nxt_div;
   logic [7:0] limit;

   // terminal count for the selected ratio
   function automatic logic [7:0] div_limit(input logic       precise,
                                            input logic [2:0] sel,
                                            input logic [7:0] ratio);
      if (precise) begin
         div_limit = ratio;
      end else begin
         div_limit = (DIV_STEP << sel) - DIV_STEP;
      end
   endfunction : div_limit

   always_comb begin
      limit    = div_limit(pif.precise, pif.sel, pif.ratio);
      pif.tick = pif.enable && (div_ff >= limit);
      if (!pif.enable || div_ff >= limit) begin
         nxt_div = RST_BYTE;
      end else begin
         nxt_div = div_ff + DIV_STEP;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff <= RST_BYTE;
      end else begin
         div_ff <= nxt_div;
      end
   end

   property p_div2;
      @(posedge pclk) disable iff (!presetn)
      (pif.tick && pif.enable && !pif.precise && pif.sel == 3'd1)
      ##1 (pif.enable && !pif.precise && pif.sel == 3'd1) [*2]
      |-> pif.tick && $past(!pif.tick);
   endproperty
   a_div2: assert property (p_div2)
      else $error("divide by two tick spacing wrong");

   property p_div3;
      @(posedge pclk) disable iff (!presetn)
      (pif.tick && pif.enable && pif.precise && pif.ratio == 8'd2)
      ##1 (pif.enable && pif.precise && pif.ratio == 8'd2) [*3]
      |-> pif.tick && $past(!pif.tick) && $past(!pif.tick, 2);
   endproperty
   a_div3: assert property (p_div3)
      else $error("precision divide by three spacing wrong");
endmodule : tcc_prescaler

// ### bench/tcc_pin_model.sv
`timescale 1ns/1ps
module tcc_pin_model (
   // clock
   input  wire logic       pclk,
   // timer pins
   input  wire logic [7:0] tc_out,
   input  wire logic [7:0] tc_oe,
   output logic      [7:0] tc_in
);
   logic [7:0] ext_ff;

   initial ext_ff = 8'h00;

   // wire level: the block where it drives, the far side elsewhere
   assign tc_in = (tc_oe & tc_out) | (~tc_oe & ext_ff);

   // high pulse on one pin, held whole clocks from a rising edge
   task automatic pulse(input int ch, input int len);
      @(posedge pclk);
      ext_ff[ch] <= 1'b1;
      repeat (len) @(posedge pclk);
      ext_ff[ch] <= 1'b0;
   endtask : pulse
endmodule : tcc_pin_model

// ### bench/timer_capture_compare_channels_test.sv
`timescale 1ns/1ps
module timer_capture_compare_channels_test
   import tcc_pkg::*;
;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  tc_in;
   logic [7:0]  tc_out;
   logic [7:0]  tc_oe;
   logic [7:0]  chan_irq;
   logic [31:0] rdata;
   logic [31:0] c1;
   logic [31:0] v;
   logic [7:0]  port;
   logic        perr;
   int          bad_count;
   int          comparisons;
   int          k;
   integer      seed;

   tcc_top #(.CH_EN(8'hBF)) u_tcc_top (
      .pclk     (pclk),
      .presetn  (presetn),
      .psel     (psel),
      .penable  (penable),
      .pwrite   (pwrite),
      .paddr    (paddr),
      .pwdata   (pwdata),
      .prdata   (prdata),
      .pready   (pready),
      .pslverr  (pslverr),
      .tc_in    (tc_in),
      .tc_out   (tc_out),
      .tc_oe    (tc_oe),
      .chan_irq (chan_irq)
   );

   tcc_pin_model u_tcc_pin_model (
      .pclk   (pclk),
      .tc_out (tc_out),
      .tc_oe  (tc_oe),
      .tc_in  (tc_in)
   );

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task automatic chk(input string nm, input logic [31:0] exp,
                      input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict

   // one apb transfer, entered and left just after a rising edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      chk("pready", 32'h1, {31'h0, pready});
      rdata = prdata;
      perr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask : rd

   // counter advance over d cycles after the divider settles
   task automatic rate(input int d, input logic [31:0] exp);
      repeat (300) @(posedge pclk);
      rd(OFS_COUNT);
      c1 = rdata;
      repeat (d - 3) @(posedge pclk);
      rd(OFS_COUNT);
      chk("count step", exp, (rdata - c1) & 32'hFFFF);
   endtask : rate

   // arm a compare on a channel 40 counts past the current count
   task automatic arm(input logic [7:0] a);
      rd(OFS_COUNT);
      wr(a, rdata + 32'h28);
   endtask : arm

   initial begin
      repeat (40000) @(posedge pclk);
      bad_count++;
      give_verdict();
   end

   initial begin
      seed = 86;
      port = 8'h00;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 15; i++) begin
         rd(8'(i * 4));
         chk("reset value", 32'h0, rdata);
      end
      rd(8'h3C);
      chk("unmapped error", 32'h1, perr);
      chk("unmapped data", 32'h0, rdata);
      wr(OFS_DIR, 32'hFF);
      rd(OFS_DIR);
      chk("absent channel", 32'hBF, rdata);
      wr(OFS_DIR, 32'h8E);
      wr(OFS_CTRL1, 32'h80);
      for (int s = 0; s < 8; s++) begin
         wr(OFS_CTRL2, 32'(s));
         rate(512, 32'(512 >> s));
      end
      wr(OFS_CTRL1, 32'h88);
      for (int j = 0; j < 4; j++) begin
         k = (j == 0) ? 0 : (j == 1) ? 255 : (j == 2) ? 2
             : ($random(seed) & 255);
         wr(OFS_PPS, 32'(k));
         rate(4 * (k + 1), 32'h4);
      end
      wr(OFS_CTRL1, 32'h80);
      wr(OFS_CTRL2, 32'h0);
      wr(OFS_IEN, 32'h03);
      for (int a = 0; a < 4; a++) begin
         wr(OFS_ACTION, 32'(a) << 2);
         arm(OFS_CHAN + 8'h04);
         repeat (60) @(posedge pclk);
         port[1] = (a == 1) ? ~port[1] : (a == 0) ? port[1] : a[0];
         chk("compare pin", {24'h0, port}, {24'h0, tc_out});
         chk("pin enable", 32'(a != 0), {31'h0, tc_oe[1]});
         chk("irq", 32'h2, {24'h0, chan_irq} & 32'h2);
         rd(OFS_FLAGS);
         chk("compare flag", 32'h2, rdata & 32'h2);
         wr(OFS_FLAGS, 32'h2);
         rd(OFS_FLAGS);
         chk("flag clear", 32'h0, rdata & 32'h2);
      end
      wr(OFS_ACTION, 32'h4);
      wr(OFS_FORCE, 32'h2);
      port[1] = ~port[1];
      chk("forced pin", {24'h0, port}, {24'h0, tc_out});
      rd(OFS_FLAGS);
      chk("forced flag", 32'h0, rdata & 32'h2);
      wr(OFS_DISC, 32'h2);
      chk("disconnect", 32'h0, {31'h0, tc_oe[1]});
      wr(OFS_DISC, 32'h0);
      wr(OFS_MASK7, 32'h6);
      wr(OFS_DATA7, 32'h4);
      wr(OFS_ACTION, 32'hFC);
      wr(OFS_CTRL2, 32'h8);
      rd(OFS_COUNT);
      wr(OFS_CHAN + 8'h1C, rdata + 32'h28);
      wr(OFS_CHAN + 8'h0C, rdata + 32'h28);
      wr(OFS_CHAN + 8'h04, rdata + 32'h20);
      repeat (60) @(posedge pclk);
      port = (port & ~8'h06) | (8'h04 & 8'h06);
      chk("ch7 port", {24'h0, port}, {24'h0, tc_out});
      rd(OFS_PORT);
      chk("port reg", {24'h0, port}, rdata);
      rd(OFS_COUNT);
      chk("count reset", 32'h1, 32'(rdata < 32'h28));
      wr(OFS_CTRL2, 32'h0);
      wr(OFS_MASK7, 32'h0);
      wr(OFS_EDGE, 32'h1);
      rd(OFS_COUNT);
      c1 = rdata;
      u_tcc_pin_model.pulse(0, 4);
      repeat (6) @(posedge pclk);
      rd(OFS_CHAN);
      v = rdata;
      rd(OFS_COUNT);
      chk("capture", 32'h1, 32'((v > c1) && (v < rdata)));
      chk("capture irq", 32'h1, {24'h0, chan_irq} & 32'h1);
      wr(OFS_CTRL1, 32'h00);
      wr(OFS_FLAGS, 32'h1);
      rd(OFS_FLAGS);
      chk("clear refused", 32'h1, rdata & 32'h1);
      wr(OFS_CTRL1, 32'h01);
      wr(OFS_FLAGS, 32'h1);
      rd(OFS_FLAGS);
      chk("clear accum", 32'h0, rdata & 32'h1);
      give_verdict();
   end
endmodule : timer_capture_compare_channels_test
